/* include/bm_pkg.sv */
// shared types and constants for the branch and byte-move execution slice
package bm_pkg;

  // opcode encodings, ? marks register or pointer select bits
  localparam logic [7:0] OPC_BR_BSC = 8'h10;
  localparam logic [7:0] OPC_BR_CY = 8'h40;
  localparam logic [7:0] OPC_BR_NCY = 8'h50;
  localparam logic [7:0] OPC_BR_BCLR = 8'h30;
  localparam logic [7:0] OPC_BR_AZ = 8'h60;
  localparam logic [7:0] OPC_BR_ANZ = 8'h70;
  localparam logic [7:0] OPC_TBL_JUMP = 8'h73;
  localparam logic [7:0] OPC_FAR_CALL = 8'h12;
  localparam logic [7:0] OPC_FAR_JUMP = 8'h02;
  localparam logic [7:0] OPC_A_BANK = 8'b1110_1???;
  localparam logic [7:0] OPC_A_DIR = 8'hE5;
  localparam logic [7:0] OPC_A_IND = 8'b1110_011?;
  localparam logic [7:0] OPC_A_IMM = 8'h74;
  localparam logic [7:0] OPC_BANK_A = 8'b1111_1???;
  localparam logic [7:0] OPC_BANK_DIR = 8'b1010_1???;
  localparam logic [7:0] OPC_BANK_IMM = 8'b0111_1???;
  localparam logic [7:0] OPC_DIR_A = 8'hF5;
  localparam logic [7:0] OPC_DIR_BANK = 8'b1000_1???;
  localparam logic [7:0] OPC_DIR_DIR = 8'h85;
  localparam logic [7:0] OPC_DIR_IND = 8'b1000_011?;
  localparam logic [7:0] OPC_DIR_IMM = 8'h75;
  localparam logic [7:0] OPC_IND_A = 8'b1111_011?;
  localparam logic [7:0] OPC_IND_DIR = 8'b1010_011?;
  localparam logic [7:0] OPC_IND_IMM = 8'b0111_011?;

  // direct address space
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_PORT = 8'h90;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam int PSW_CY = 7;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int REG_SEL_HI = 2;
  localparam int IND_SEL = 0;

  // reset values and steps
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [7:0] PORT_RST = 8'hFF;
  localparam logic [7:0] SP_STEP = 8'h01;
  localparam logic [15:0] PC_STEP = 16'h0001;

  // instruction length and documented cycle count
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;

  // memory access phases: address out, memory registers, data taken
  localparam logic [1:0] PH_ISSUE = 2'h0;
  localparam logic [1:0] PH_WAIT = 2'h1;
  localparam logic [1:0] PH_TAKE = 2'h2;
  localparam logic [1:0] IDX_OP = 2'h0;
  localparam logic [1:0] IDX_B2 = 2'h1;
  localparam logic [1:0] IDX_STEP = 2'h1;

  typedef enum logic [2:0] {S_FETCH, S_PTR, S_SRC, S_EXEC, S_PUSH} state_t;
  typedef enum logic [3:0] {
    C_NONE, C_BSC, C_CY, C_NCY, C_BCLR, C_AZ, C_ANZ, C_TBL, C_CALL, C_JUMP, C_COPY
  } cls_t;
  typedef enum logic [2:0] {K_NONE, K_ACC, K_REG, K_DIR, K_IND, K_IMM} kind_t;

  typedef struct packed {
    cls_t cls;
    kind_t src;
    kind_t dst;
    logic [1:0] bytes;
    logic [1:0] cycles;
  } dec_t;

  typedef struct packed {
    logic [7:0] addr;
    logic we;
    logic [7:0] wdata;
  } ram_req_t;

  typedef struct packed {
    state_t state;
    logic [1:0] phase;
    logic [1:0] idx;
    logic [15:0] pc;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] ptr;
    logic [7:0] src;
    logic [7:0] acc;
    logic [7:0] psw;
    logic [7:0] sp;
    logic [7:0] dpl;
    logic [7:0] dph;
    logic [7:0] port;
    logic [15:0] pmem_addr;
    ram_req_t ram;
    logic retire;
    logic bad_op;
    logic [1:0] op_bytes;
    logic [1:0] op_cycles;
  } core_t;

  localparam core_t CORE_RST = '{state: S_FETCH, sp: SP_RST, port: PORT_RST, default: '0};

endpackage

/* verilog/int_ram.sv */
// internal data memory with registered read data
`timescale 1ns/1ps
module int_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_ff [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  // contents carry no reset, as real ram does not
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_ff[addr] <= wdata;
    end
  end

  // read before write on the same address
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[addr];
    end
  end

  assign rdata = rdata_ff;

endmodule

/* verilog/branch_and_move_execution.sv */
// decode and execute core for relative branches, far jumps and calls, and byte moves
// Behaviour
// - bit-set branch clears bit, always; 3 bytes
// - that branch reads output latch, not pin
// - advance pc first, then add third byte
// - carry-set branch: pc+2, add when carry
// - carry-clear branch: pc+2, add when no carry
// - table jump: pc gets accumulator plus pointer
// - bit-clear branch taken on zero, unmodified
// - accumulator nonzero branch after pc+2
// - accumulator zero branch, nothing modified
// - far call pushes pc+3 low first
// - far jump loads pc from bytes two, three
// - byte copy changes only the destination
// - copy of accumulator onto itself is invalid
// - accumulator and bank register moves, one byte
// - direct into accumulator, two bytes
// - indirect into accumulator through pointer zero/one
// - immediate loads of accumulator and bank register
// - direct into bank register, two bytes
// - accumulator or bank register into direct
// - direct to direct: source second, destination third
`timescale 1ns/1ps
module branch_and_move_execution #(
  parameter int RAM_AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] pmem_rdata,
  input wire logic [7:0] port_pin,
  output logic [15:0] pmem_addr,
  output logic [7:0] port_latch,
  output logic retire,
  output logic bad_op,
  output logic [1:0] op_bytes,
  output logic [1:0] op_cycles
);

  bm_pkg::core_t cur_ff;
  bm_pkg::core_t nxt_cur;
  bm_pkg::dec_t dec;
  logic [7:0] ram_rdata;

  function automatic bm_pkg::dec_t decode(input logic [7:0] op);
    bm_pkg::dec_t d;
    d.cls = bm_pkg::C_NONE;
    d.src = bm_pkg::K_NONE;
    d.dst = bm_pkg::K_NONE;
    d.bytes = bm_pkg::LEN_1;
    d.cycles = bm_pkg::CYC_1;
    casez (op)
      bm_pkg::OPC_BR_BSC: begin
        d.cls = bm_pkg::C_BSC;
        d.bytes = bm_pkg::LEN_3;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_BR_BCLR: begin
        d.cls = bm_pkg::C_BCLR;
        d.bytes = bm_pkg::LEN_3;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_BR_CY: begin
        d.cls = bm_pkg::C_CY;
        d.bytes = bm_pkg::LEN_2;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_BR_NCY: begin
        d.cls = bm_pkg::C_NCY;
        d.bytes = bm_pkg::LEN_2;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_BR_AZ: begin
        d.cls = bm_pkg::C_AZ;
        d.bytes = bm_pkg::LEN_2;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_BR_ANZ: begin
        d.cls = bm_pkg::C_ANZ;
        d.bytes = bm_pkg::LEN_2;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_TBL_JUMP: begin
        d.cls = bm_pkg::C_TBL;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_FAR_CALL: begin
        d.cls = bm_pkg::C_CALL;
        d.bytes = bm_pkg::LEN_3;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_FAR_JUMP: begin
        d.cls = bm_pkg::C_JUMP;
        d.bytes = bm_pkg::LEN_3;
        d.cycles = bm_pkg::CYC_2;
      end
      bm_pkg::OPC_A_BANK, bm_pkg::OPC_BANK_A: begin
        d.cls = bm_pkg::C_COPY;
        d.src = op[3] ? bm_pkg::K_ACC : bm_pkg::K_REG;
        d.dst = op[3] ? bm_pkg::K_REG : bm_pkg::K_ACC;
        if (op[4]) begin
          d.src = bm_pkg::K_ACC;
          d.dst = bm_pkg::K_REG;
        end else begin
          d.src = bm_pkg::K_REG;
          d.dst = bm_pkg::K_ACC;
        end
      end
      bm_pkg::OPC_A_DIR: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_DIR, bm_pkg::K_ACC, bm_pkg::LEN_2, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_A_IND: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IND, bm_pkg::K_ACC, bm_pkg::LEN_1, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_A_IMM: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IMM, bm_pkg::K_ACC, bm_pkg::LEN_2, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_BANK_IMM: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IMM, bm_pkg::K_REG, bm_pkg::LEN_2, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_BANK_DIR: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_DIR, bm_pkg::K_REG, bm_pkg::LEN_2, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_DIR_A: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_ACC, bm_pkg::K_DIR, bm_pkg::LEN_2, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_DIR_BANK: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_REG, bm_pkg::K_DIR, bm_pkg::LEN_2, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_DIR_DIR: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_DIR, bm_pkg::K_DIR, bm_pkg::LEN_3, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_DIR_IND: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IND, bm_pkg::K_DIR, bm_pkg::LEN_2, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_DIR_IMM: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IMM, bm_pkg::K_DIR, bm_pkg::LEN_3, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_IND_A: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_ACC, bm_pkg::K_IND, bm_pkg::LEN_1, bm_pkg::CYC_1};
      end
      bm_pkg::OPC_IND_DIR: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_DIR, bm_pkg::K_IND, bm_pkg::LEN_2, bm_pkg::CYC_2};
      end
      bm_pkg::OPC_IND_IMM: begin
        d = '{bm_pkg::C_COPY, bm_pkg::K_IMM, bm_pkg::K_IND, bm_pkg::LEN_2, bm_pkg::CYC_1};
      end
      default: begin
        d.cls = bm_pkg::C_NONE;
      end
    endcase
    return d;
  endfunction

  // bank register address from the bank select bits of the status word
  function automatic logic [7:0] bank_reg(input logic [7:0] psw, input logic [2:0] r);
    return {3'h0, psw[bm_pkg::PSW_RS_HI:bm_pkg::PSW_RS_LO], r};
  endfunction

  // byte that holds an addressed bit
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    if (a < bm_pkg::SFR_BASE) begin
      return bm_pkg::BIT_RAM_BASE + {4'h0, a[6:3]};
    end
    return {a[7:3], 3'h0};
  endfunction

  // sign extension keeps the target inside the 16-bit space
  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] rel);
    return pc + {{8{rel[7]}}, rel};
  endfunction

  function automatic logic [7:0] rd_direct(input bm_pkg::core_t s, input logic [7:0] a, input logic [7:0] ram_d,
                                           input logic [7:0] pins, input logic use_latch);
    logic [7:0] v;
    v = 8'h00;
    if (a < bm_pkg::SFR_BASE) begin
      v = ram_d;
    end else begin
      case (a)
        bm_pkg::SFR_ACC: v = s.acc;
        bm_pkg::SFR_PSW: v = s.psw;
        bm_pkg::SFR_SP: v = s.sp;
        bm_pkg::SFR_DPL: v = s.dpl;
        bm_pkg::SFR_DPH: v = s.dph;
        bm_pkg::SFR_PORT: v = use_latch ? s.port : pins;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  function automatic bm_pkg::core_t ram_write(input bm_pkg::core_t s, input logic [7:0] a, input logic [7:0] d);
    bm_pkg::core_t r;
    r = s;
    r.ram.addr = a;
    r.ram.we = 1'b1;
    r.ram.wdata = d;
    return r;
  endfunction

  // writes to unmapped special registers are dropped
  function automatic bm_pkg::core_t wr_direct(input bm_pkg::core_t s, input logic [7:0] a, input logic [7:0] d);
    bm_pkg::core_t r;
    r = s;
    if (a < bm_pkg::SFR_BASE) begin
      r = ram_write(s, a, d);
    end else begin
      case (a)
        bm_pkg::SFR_ACC: r.acc = d;
        bm_pkg::SFR_PSW: r.psw = d;
        bm_pkg::SFR_SP: r.sp = d;
        bm_pkg::SFR_DPL: r.dpl = d;
        bm_pkg::SFR_DPH: r.dph = d;
        bm_pkg::SFR_PORT: r.port = d;
        default: r = s;
      endcase
    end
    return r;
  endfunction

  int_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .addr(cur_ff.ram.addr[RAM_AW-1:0]),
    .we(cur_ff.ram.we),
    .wdata(cur_ff.ram.wdata),
    .rdata(ram_rdata)
  );

  assign dec = decode(cur_ff.op);

  always_comb begin
    logic more;
    logic need_ptr;
    logic need_bit;
    logic bit_val;
    logic take;
    logic [7:0] imm_byte;
    logic [7:0] dst_dir;
    logic [2:0] rsel;
    logic [2:0] isel;
    more = 1'b0;
    need_ptr = (dec.src == bm_pkg::K_IND) || (dec.dst == bm_pkg::K_IND);
    need_bit = (dec.cls == bm_pkg::C_BSC) || (dec.cls == bm_pkg::C_BCLR);
    bit_val = cur_ff.src[cur_ff.b2[2:0]];
    take = 1'b0;
    imm_byte = (dec.dst == bm_pkg::K_DIR) ? cur_ff.b3 : cur_ff.b2;
    dst_dir = (dec.src == bm_pkg::K_DIR) ? cur_ff.b3 : cur_ff.b2;
    rsel = cur_ff.op[bm_pkg::REG_SEL_HI:0];
    isel = {2'h0, cur_ff.op[bm_pkg::IND_SEL]};
    nxt_cur = cur_ff;
    nxt_cur.retire = 1'b0;
    nxt_cur.bad_op = 1'b0;
    nxt_cur.ram.we = 1'b0;
    case (cur_ff.state)
      bm_pkg::S_FETCH: begin
        case (cur_ff.phase)
          bm_pkg::PH_ISSUE: begin
            nxt_cur.pmem_addr = cur_ff.pc;
            nxt_cur.phase = bm_pkg::PH_WAIT;
          end
          bm_pkg::PH_WAIT: begin
            nxt_cur.phase = bm_pkg::PH_TAKE;
          end
          default: begin
            // pc passes every byte before any target is formed
            nxt_cur.pc = cur_ff.pc + bm_pkg::PC_STEP;
            nxt_cur.phase = bm_pkg::PH_ISSUE;
            if (cur_ff.idx == bm_pkg::IDX_OP) begin
              nxt_cur.op = pmem_rdata;
              more = decode(pmem_rdata).bytes > bm_pkg::LEN_1;
            end else if (cur_ff.idx == bm_pkg::IDX_B2) begin
              nxt_cur.b2 = pmem_rdata;
              more = dec.bytes > bm_pkg::LEN_2;
            end else begin
              nxt_cur.b3 = pmem_rdata;
            end
            if (more) begin
              nxt_cur.idx = cur_ff.idx + bm_pkg::IDX_STEP;
            end else begin
              nxt_cur.idx = bm_pkg::IDX_OP;
              nxt_cur.state = bm_pkg::S_PTR;
            end
          end
        endcase
      end
      bm_pkg::S_PTR: begin
        if (!need_ptr && !need_bit) begin
          nxt_cur.state = bm_pkg::S_SRC;
        end else begin
          case (cur_ff.phase)
            bm_pkg::PH_ISSUE: begin
              nxt_cur.ram.addr = need_bit ? bit_byte(cur_ff.b2) : bank_reg(cur_ff.psw, isel);
              nxt_cur.phase = bm_pkg::PH_WAIT;
            end
            bm_pkg::PH_WAIT: begin
              nxt_cur.phase = bm_pkg::PH_TAKE;
            end
            default: begin
              if (need_bit) begin
                nxt_cur.src = rd_direct(cur_ff, bit_byte(cur_ff.b2), ram_rdata, port_pin,
                                        dec.cls == bm_pkg::C_BSC);
              end else begin
                nxt_cur.ptr = ram_rdata;
              end
              nxt_cur.phase = bm_pkg::PH_ISSUE;
              nxt_cur.state = bm_pkg::S_SRC;
            end
          endcase
        end
      end
      bm_pkg::S_SRC: begin
        case (dec.src)
          bm_pkg::K_ACC: begin
            nxt_cur.src = cur_ff.acc;
            nxt_cur.state = bm_pkg::S_EXEC;
          end
          bm_pkg::K_IMM: begin
            nxt_cur.src = imm_byte;
            nxt_cur.state = bm_pkg::S_EXEC;
          end
          bm_pkg::K_REG, bm_pkg::K_DIR, bm_pkg::K_IND: begin
            case (cur_ff.phase)
              bm_pkg::PH_ISSUE: begin
                if (dec.src == bm_pkg::K_REG) begin
                  nxt_cur.ram.addr = bank_reg(cur_ff.psw, rsel);
                end else if (dec.src == bm_pkg::K_DIR) begin
                  nxt_cur.ram.addr = cur_ff.b2;
                end else begin
                  nxt_cur.ram.addr = cur_ff.ptr;
                end
                nxt_cur.phase = bm_pkg::PH_WAIT;
              end
              bm_pkg::PH_WAIT: begin
                nxt_cur.phase = bm_pkg::PH_TAKE;
              end
              default: begin
                nxt_cur.src = (dec.src == bm_pkg::K_DIR) ? rd_direct(cur_ff, cur_ff.b2, ram_rdata, port_pin, 1'b0)
                                                        : ram_rdata;
                nxt_cur.phase = bm_pkg::PH_ISSUE;
                nxt_cur.state = bm_pkg::S_EXEC;
              end
            endcase
          end
          default: begin
            nxt_cur.state = bm_pkg::S_EXEC;
          end
        endcase
      end
      bm_pkg::S_EXEC: begin
        nxt_cur.state = bm_pkg::S_FETCH;
        nxt_cur.retire = 1'b1;
        nxt_cur.op_bytes = dec.bytes;
        nxt_cur.op_cycles = dec.cycles;
        case (dec.cls)
          bm_pkg::C_BSC: begin
            // write-back happens on both outcomes
            nxt_cur = wr_direct(nxt_cur, bit_byte(cur_ff.b2),
                                cur_ff.src & ~(8'h01 << cur_ff.b2[2:0]));
            take = bit_val;
          end
          bm_pkg::C_BCLR: take = !bit_val;
          bm_pkg::C_CY: take = cur_ff.psw[bm_pkg::PSW_CY];
          bm_pkg::C_NCY: take = !cur_ff.psw[bm_pkg::PSW_CY];
          bm_pkg::C_AZ: take = (cur_ff.acc == 8'h00);
          bm_pkg::C_ANZ: take = (cur_ff.acc != 8'h00);
          bm_pkg::C_TBL: begin
            nxt_cur.pc = {cur_ff.dph, cur_ff.dpl} + {8'h00, cur_ff.acc};
          end
          bm_pkg::C_JUMP: begin
            nxt_cur.pc = {cur_ff.b2, cur_ff.b3};
          end
          bm_pkg::C_CALL: begin
            nxt_cur.sp = cur_ff.sp + bm_pkg::SP_STEP;
            nxt_cur = ram_write(nxt_cur, cur_ff.sp + bm_pkg::SP_STEP, cur_ff.pc[7:0]);
            nxt_cur.retire = 1'b0;
            nxt_cur.state = bm_pkg::S_PUSH;
          end
          bm_pkg::C_COPY: begin
            case (dec.dst)
              bm_pkg::K_ACC: nxt_cur.acc = cur_ff.src;
              bm_pkg::K_REG: nxt_cur = ram_write(nxt_cur, bank_reg(cur_ff.psw, rsel), cur_ff.src);
              bm_pkg::K_DIR: nxt_cur = wr_direct(nxt_cur, dst_dir, cur_ff.src);
              bm_pkg::K_IND: nxt_cur = ram_write(nxt_cur, cur_ff.ptr, cur_ff.src);
              default: nxt_cur.acc = cur_ff.acc;
            endcase
            // accumulator result stays a plain copy; only the flag marks it
            nxt_cur.bad_op = (dec.src == bm_pkg::K_DIR) && (dec.dst == bm_pkg::K_ACC)
                             && (cur_ff.b2 == bm_pkg::SFR_ACC);
          end
          default: nxt_cur.pc = cur_ff.pc;
        endcase
        if (take) begin
          nxt_cur.pc = rel_target(cur_ff.pc, (dec.bytes == bm_pkg::LEN_3) ? cur_ff.b3 : cur_ff.b2);
        end
      end
      bm_pkg::S_PUSH: begin
        nxt_cur.sp = cur_ff.sp + bm_pkg::SP_STEP;
        nxt_cur = ram_write(nxt_cur, cur_ff.sp + bm_pkg::SP_STEP, cur_ff.pc[15:8]);
        nxt_cur.pc = {cur_ff.b2, cur_ff.b3};
        nxt_cur.retire = 1'b1;
        nxt_cur.op_bytes = dec.bytes;
        nxt_cur.op_cycles = dec.cycles;
        nxt_cur.state = bm_pkg::S_FETCH;
      end
      default: begin
        nxt_cur.state = bm_pkg::S_FETCH;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_ff <= bm_pkg::CORE_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pmem_addr = cur_ff.pmem_addr;
  assign port_latch = cur_ff.port;
  assign retire = cur_ff.retire;
  assign bad_op = cur_ff.bad_op;
  assign op_bytes = cur_ff.op_bytes;
  assign op_cycles = cur_ff.op_cycles;

endmodule

/* tb/bm_chk.sv */
// port checks for the execution core
`timescale 1ns/1ps
module bm_chk #(parameter int RAM_AW = 8) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] pmem_addr,
  input wire logic [7:0] port_latch,
  input wire logic retire,
  input wire logic bad_op,
  input wire logic [1:0] op_bytes,
  input wire logic [1:0] op_cycles
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  bad_len_a: assert property (bad_op |-> retire && op_bytes == 2'h2 && op_cycles == 2'h1)
    else $error("invalid self move length wrong");
  long_cyc_a: assert property (retire && op_bytes == 2'h3 |-> op_cycles == 2'h2)
    else $error("three byte op not two cycles");
  len_legal_a: assert property (retire |-> op_bytes != 2'h0 && op_cycles inside {2'h1, 2'h2})
    else $error("retired length out of range");
  len_hold_a: assert property (!retire && $past(rst_n) |-> $stable(op_bytes) && $stable(op_cycles))
    else $error("length moved without retire");
  retire_gap_a: assert property (retire |=> !retire [*2] ##[1:60] retire)
    else $error("retire spacing wrong");
  fetch_hold_a: assert property ($changed(pmem_addr) && $past(rst_n) |=> $stable(pmem_addr) [*2])
    else $error("fetch address not held");
  port_cause_a: assert property ($changed(port_latch) && $past(rst_n) |-> ##[0:1] retire)
    else $error("port latch moved outside an instruction");
  rst_vals_a: assert property ($rose(rst_n) |-> pmem_addr == 16'h0000 && port_latch == 8'hFF)
    else $error("reset values wrong");
endmodule
bind branch_and_move_execution bm_chk #(.RAM_AW(RAM_AW)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .pmem_addr(pmem_addr), .port_latch(port_latch), .retire(retire), .bad_op(bad_op),
  .op_bytes(op_bytes), .op_cycles(op_cycles));

/* tb/prog_mem.sv */
// program memory model, data one edge after the address
`timescale 1ns/1ps
module prog_mem (
  input wire logic sys_clk,
  input wire logic [15:0] pmem_addr,
  output logic [7:0] pmem_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  always_ff @(posedge sys_clk) pmem_rdata <= mem[pmem_addr];
endmodule

/* tb/tb_top.sv */
// bench: short random programs through the execution core
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] port_pin = 8'h00;
  logic [7:0] pmem_rdata, port_latch;
  logic [15:0] pmem_addr;
  logic retire, bad_op;
  logic [1:0] op_bytes, op_cycles;
  int err_total = 0;
  int checked = 0;
  // retires of a previous program's idle loop must not eat the next queue
  bit chk_on = 1'b0;
  logic [4:0] expq[$];
  logic [7:0] prog[$];
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  prog_mem rom (.sys_clk(sys_clk), .pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
  branch_and_move_execution #(.RAM_AW(8)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .pmem_rdata(pmem_rdata),
    .port_pin(port_pin), .pmem_addr(pmem_addr), .port_latch(port_latch), .retire(retire),
    .bad_op(bad_op), .op_bytes(op_bytes), .op_cycles(op_cycles));
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // each retire while chk_on is set and the queue is not empty is matched against the queued length and cycle count
  always @(posedge sys_clk) begin
    if (chk_on && rst_n && retire === 1'b1 && expq.size() > 0) begin
      cmp("length", {3'h0, expq.pop_front()}, {3'h0, bad_op, op_bytes, op_cycles});
    end
  end
  task automatic ins(input logic [7:0] a, b = 8'h00, c = 8'h00, input int n = 1,
                     input logic [1:0] cy = 2'h1, input logic bad = 1'b0, input bit q = 1'b1);
    prog.push_back(a);
    if (n > 1) prog.push_back(b);
    if (n > 2) prog.push_back(c);
    if (q) expq.push_back({bad, 2'(n), cy});
  endtask
  task automatic at(input logic [15:0] ad);
    while (prog.size() < ad) prog.push_back(8'h00);
  endtask
  task automatic run(input logic [7:0] pv, ep, input string nm);
    int k;
    @(posedge sys_clk);
    for (k = 0; k < prog.size(); k++) rom.mem[k] = prog[k];
    rst_n <= 1'b0;
    port_pin <= pv;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_on = 1'b1;
    for (k = 0; k < 3000 && expq.size() > 0; k++) @(posedge sys_clk);
    chk_on = 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp("pending", 8'h00, 8'(expq.size()));
    cmp(nm, ep, port_latch);
    for (k = 0; k < prog.size(); k++) rom.mem[k] = 8'h00;
    prog.delete();
    expq.delete();
    $display("test %s done", nm);
  endtask
  // taken target sits behind the branch, so the displacement is negative
  task automatic br(input logic [7:0] op, bt, v, ep, input int n, input logic [23:0] mk, input logic [7:0] sf,
                    input string nm);
    logic [7:0] rel;
    rel = 8'h03 - 8'h0E - 8'(n);
    ins(8'h02, 8'h00, 8'h0B, 3, 2'h2);
    ins(mk[23:16], mk[15:8], mk[7:0], 3, 2'h2, 1'b0, 1'b0);
    ins(8'h02, 8'h00, 8'h06, 3, 2'h2, 1'b0, 1'b0);
    at(16'h000B);
    ins(8'h75, sf, v, 3, 2'h2);
    if (n == 2) ins(op, rel, 8'h00, 2, 2'h2);
    else ins(op, bt, rel, 3, 2'h2);
    ins(8'h75, 8'h90, 8'hAA, 3, 2'h2);
    ins(8'h02, 8'h00, 8'h11 + 8'(n), 3, 2'h2);
    run(~v, ep, nm);
  endtask
  initial begin
    logic [7:0] v, w;
    logic [15:0] x, t, u;
    int i, k;
    i = $urandom(79);
    for (i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      w = ~v;
      k = $urandom_range(7, 0);
      br(8'h60, 8'h00, v, v == 8'h00 ? 8'h55 : 8'hAA, 2, 24'h759055, 8'hE0, "acc zero");
      br(8'h70, 8'h00, v, v != 8'h00 ? 8'h55 : 8'hAA, 2, 24'h759055, 8'hE0, "acc nonzero");
      br(8'h40, 8'h00, v, v[7] ? 8'h55 : 8'hAA, 2, 24'h759055, 8'hD0, "carry set");
      br(8'h50, 8'h00, v, !v[7] ? 8'h55 : 8'hAA, 2, 24'h759055, 8'hD0, "carry clear");
      br(8'h30, 8'h90 + 8'(k), v, v[k] ? 8'h55 : 8'hAA, 3, 24'h759055, 8'h90, "bit clear");
      br(8'h10, 8'hE0 + 8'(k), v, v[k] ? v & ~(8'h01 << k) : 8'hAA, 3, 24'h85E090, 8'hE0, "bit set");
      br(8'h10, 8'h90 + 8'(k), v, v[k] ? w : 8'hAA, 3, 24'h859090, 8'h90, "bit set port");
      ins(8'h74, v, 8'h00, 2);
      ins(8'hF8);
      ins(8'h88, 8'h40, 8'h00, 2, 2'h2);
      ins(8'h85, 8'h40, 8'h41, 3, 2'h2);
      ins(8'hA9, 8'h41, 8'h00, 2, 2'h2);
      ins(8'hE9);
      ins(8'h79, 8'h41, 8'h00, 2);
      ins(8'h74, w, 8'h00, 2);
      ins(8'hE7);
      ins(8'hF5, 8'h42, 8'h00, 2);
      ins(8'h74, w, 8'h00, 2);
      ins(8'hE5, 8'h42, 8'h00, 2);
      ins(8'hF5, 8'h90, 8'h00, 2);
      ins(8'hE5, 8'hE0, 8'h00, 2, 2'h1, 1'b1);
      ins(8'h02, 8'h00, 8'h1A, 3, 2'h2);
      run(8'($urandom), v, "moves");
      x = {8'($urandom_range(250, 1)), 8'($urandom_range(200, 0))};
      t = x + 16'h0008;
      ins(8'h02, x[15:8], x[7:0], 3, 2'h2);
      at(x);
      ins(8'h12, t[15:8], t[7:0], 3, 2'h2);
      at(t);
      ins(8'h85, 8'h08 + 8'(i % 2), 8'h90, 3, 2'h2);
      ins(8'h02, t[15:8], t[7:0] + 8'h03, 3, 2'h2);
      x = x + 16'h0003;
      run(8'h00, (i % 2) ? x[15:8] : x[7:0], "far call");
      x = {8'($urandom_range(250, 1)), 8'hF0 | 8'($urandom)};
      t = x + {8'h00, v | 8'h10};
      u = t + 16'h0003;
      ins(8'h75, 8'h82, x[7:0], 3, 2'h2);
      ins(8'h75, 8'h83, x[15:8], 3, 2'h2);
      ins(8'h75, 8'hE0, v | 8'h10, 3, 2'h2);
      ins(8'h73, 8'h00, 8'h00, 1, 2'h2);
      at(t);
      ins(8'h75, 8'h90, 8'hC3, 3, 2'h2);
      ins(8'h02, u[15:8], u[7:0], 3, 2'h2);
      run(8'h00, 8'hC3, "table jump");
    end
    end_of_test();
  end
  // watchdog, far beyond the expected run of a few thousand cycles
  initial begin
    #(50 * 90000);
    err_total++;
    end_of_test();
  end
endmodule
